// ==== verilog/serial_flow_pkg.sv ====
package serial_flow_pkg;

  // In-band flow control characters
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;

  // Receive buffer sizing
  localparam int RX_BUF_WIDTH = 13;
  localparam logic [12:0] RX_BUF_DEFAULT = 13'h0FFE;
  localparam logic [12:0] RX_BUF_MIN = 13'h0020;

  // Receive FIFO trigger levels, selected by a 2-bit code
  localparam logic [12:0] RX_TRIG_0 = 13'h0001;
  localparam logic [12:0] RX_TRIG_1 = 13'h0004;
  localparam logic [12:0] RX_TRIG_2 = 13'h0008;
  localparam logic [12:0] RX_TRIG_3 = 13'h000E;

  typedef enum logic [1:0] {
    PROFILE_NONE,
    PROFILE_HARDWARE,
    PROFILE_SOFTWARE,
    PROFILE_SPECIAL
  } profile_t;

  typedef enum logic [1:0] {
    OUT_FLOW,
    OUT_SHOW_CONN,
    OUT_UNUSED_HIGH,
    OUT_UNUSED_LOW
  } out_func_t;

  typedef enum logic [1:0] {
    IN_FLOW,
    IN_OPEN_CLOSE,
    IN_ACCEPT_GATE,
    IN_IGNORED
  } in_func_t;

endpackage : serial_flow_pkg

// ==== verilog/serial_flow_control_line_config.sv ====
`timescale 1ns/1ns
module serial_flow_control_line_config
  import serial_flow_pkg::*;
#(
  parameter int RX_BUF_DEPTH = 4096
) (
  input wire logic core_clk,
  input wire logic resetn,
  // Configuration, taken on cfg_save
  input wire logic cfg_save,
  input wire logic [1:0] cfg_profile,
  input wire logic [1:0] cfg_rts_func,
  input wire logic [1:0] cfg_dtr_func,
  input wire logic [1:0] cfg_cts_func,
  input wire logic [1:0] cfg_dsr_func,
  input wire logic cfg_xon_rx_en,
  input wire logic cfg_xon_tx_en,
  input wire logic cfg_tx_filter,
  input wire logic cfg_rx_filter,
  input wire logic [12:0] cfg_rx_buf_size,
  input wire logic cfg_fifo_en,
  input wire logic [1:0] cfg_fifo_trig,
  // Network connection side
  input wire logic tcp_connected,
  input wire logic client_mode,
  input wire logic dest_stored,
  input wire logic rts_ovr_en,
  input wire logic rts_ovr_level,
  input wire logic dtr_ovr_en,
  input wire logic dtr_ovr_level,
  output logic conn_open_req,
  output logic conn_close_req,
  output logic accept_allow,
  // Network to serial data
  input wire logic [7:0] net_tx_data,
  input wire logic net_tx_valid,
  output logic net_tx_ready,
  output logic [7:0] ser_tx_data,
  output logic ser_tx_valid,
  input wire logic ser_tx_ready,
  // Serial to network data
  input wire logic [7:0] ser_rx_data,
  input wire logic ser_rx_valid,
  output logic [7:0] net_rx_data,
  output logic net_rx_valid,
  input wire logic net_rx_ready,
  output logic rx_trigger_hit,
  output logic [12:0] rx_level,
  // Control lines
  output logic rts_out,
  output logic dtr_out,
  input wire logic cts_in,
  input wire logic dsr_in
);

  localparam int PTR_W = $clog2(RX_BUF_DEPTH);

  // Pointers wrap by overflow, so the depth must be a power of two
  if (RX_BUF_DEPTH < 32'(RX_BUF_DEFAULT) || RX_BUF_DEPTH >= 8192
      || (1 << PTR_W) != RX_BUF_DEPTH) begin : g_depth_check
    $error("RX_BUF_DEPTH must hold the default buffer size");
  end

  // Active settings
  out_func_t rts_f, dtr_f, next_rts_f, next_dtr_f;
  in_func_t cts_f, dsr_f, next_cts_f, next_dsr_f;
  logic xrx_en, xtx_en, tflt, rflt, fifo_en;
  logic next_xrx_en, next_xtx_en, next_tflt, next_rflt, next_fifo_en;
  logic [1:0] trig, next_trig;
  logic [12:0] buf_size, next_buf_size, sane_size;

  // Size sanitising: even, clamped to 32..4094
  always_comb begin
    sane_size = {cfg_rx_buf_size[12:1], 1'b0};
    if (sane_size < RX_BUF_MIN) begin
      sane_size = RX_BUF_MIN;
    end else if (sane_size > RX_BUF_DEFAULT) begin
      sane_size = RX_BUF_DEFAULT;
    end
  end

  // Settings latch only on save; fixed profiles overwrite custom values
  always_comb begin
    next_rts_f = rts_f;
    next_dtr_f = dtr_f;
    next_cts_f = cts_f;
    next_dsr_f = dsr_f;
    next_xrx_en = xrx_en;
    next_xtx_en = xtx_en;
    next_tflt = tflt;
    next_rflt = rflt;
    next_buf_size = buf_size;
    next_fifo_en = fifo_en;
    next_trig = trig;
    if (cfg_save) begin
      next_buf_size = sane_size;
      next_fifo_en = cfg_fifo_en;
      next_trig = cfg_fifo_trig;
      next_xrx_en = 1'b0;
      next_xtx_en = 1'b0;
      next_tflt = 1'b0;
      next_rflt = 1'b0;
      next_rts_f = OUT_UNUSED_HIGH;
      next_dtr_f = OUT_UNUSED_HIGH;
      next_cts_f = IN_IGNORED;
      next_dsr_f = IN_IGNORED;
      case (profile_t'(cfg_profile))
        PROFILE_NONE: begin
        end
        PROFILE_HARDWARE: begin
          next_rts_f = OUT_FLOW;
          next_dtr_f = OUT_SHOW_CONN;
          next_cts_f = IN_FLOW;
        end
        PROFILE_SOFTWARE: begin
          next_xrx_en = 1'b1;
          next_xtx_en = 1'b1;
          next_tflt = 1'b1;
          next_rflt = 1'b1;
        end
        PROFILE_SPECIAL: begin
          next_rts_f = out_func_t'(cfg_rts_func);
          next_dtr_f = out_func_t'(cfg_dtr_func);
          next_cts_f = in_func_t'(cfg_cts_func);
          next_dsr_f = in_func_t'(cfg_dsr_func);
          next_xrx_en = cfg_xon_rx_en;
          next_xtx_en = cfg_xon_tx_en;
          next_tflt = cfg_tx_filter;
          next_rflt = cfg_rx_filter;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rts_f <= OUT_FLOW;
      dtr_f <= OUT_SHOW_CONN;
      cts_f <= IN_FLOW;
      dsr_f <= IN_IGNORED;
      xrx_en <= 1'b0;
      xtx_en <= 1'b0;
      tflt <= 1'b0;
      rflt <= 1'b0;
      buf_size <= RX_BUF_DEFAULT;
      fifo_en <= 1'b0;
      trig <= 2'h0;
    end else begin
      rts_f <= next_rts_f;
      dtr_f <= next_dtr_f;
      cts_f <= next_cts_f;
      dsr_f <= next_dsr_f;
      xrx_en <= next_xrx_en;
      xtx_en <= next_xtx_en;
      tflt <= next_tflt;
      rflt <= next_rflt;
      buf_size <= next_buf_size;
      fifo_en <= next_fifo_en;
      trig <= next_trig;
    end
  end

  // Receive buffer storage and pointers
  logic [7:0] rx_mem [RX_BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [12:0] next_rx_level;
  logic rx_full, rx_is_ctrl, rx_push, rx_pop, xoff_held, next_xoff_held;
  logic [7:0] slot0, slot1, next_slot0, next_slot1;
  logic [1:0] slot_cnt, next_slot_cnt;
  logic net_pop;

  assign rx_full = rx_level >= buf_size;
  assign rx_is_ctrl = ser_rx_data == XON_CHAR || ser_rx_data == XOFF_CHAR;
  // Control bytes are swallowed when filtered or used for flow control
  assign rx_push = ser_rx_valid && !rx_full && !(rx_is_ctrl && (rflt || xrx_en));
  assign net_pop = net_rx_valid && net_rx_ready;
  assign rx_pop = rx_level != 13'h0000 && (slot_cnt != 2'h2 || net_pop);

  // Pointer, level and terminal XOFF state
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_rx_level = rx_level;
    next_xoff_held = xoff_held;
    if (rx_push) begin
      next_wr_ptr = PTR_W'(wr_ptr + 1'b1);
    end
    if (rx_pop) begin
      next_rd_ptr = PTR_W'(rd_ptr + 1'b1);
    end
    next_rx_level = 13'(rx_level + {12'h000, rx_push} - {12'h000, rx_pop});
    if (xrx_en && ser_rx_valid && ser_rx_data == XOFF_CHAR) begin
      next_xoff_held = 1'b1;
    end else if (xrx_en && ser_rx_valid && ser_rx_data == XON_CHAR) begin
      next_xoff_held = 1'b0;
    end
    if (cfg_save) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_rx_level = 13'h0000;
      next_xoff_held = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      rx_level <= 13'h0000;
      xoff_held <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      rx_level <= next_rx_level;
      xoff_held <= next_xoff_held;
    end
  end

  // Storage array write, no reset needed
  always_ff @(posedge core_clk) begin
    if (rx_push) begin
      rx_mem[wr_ptr] <= ser_rx_data;
    end
  end

  // Two-entry output buffer toward the network
  always_comb begin
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_slot_cnt = slot_cnt;
    if (net_pop) begin
      next_slot0 = slot1;
      next_slot_cnt = 2'(slot_cnt - 2'h1);
    end
    if (rx_pop) begin
      if (next_slot_cnt == 2'h0) begin
        next_slot0 = rx_mem[rd_ptr];
      end else begin
        next_slot1 = rx_mem[rd_ptr];
      end
      next_slot_cnt = 2'(next_slot_cnt + 2'h1);
    end
    if (cfg_save) begin
      next_slot_cnt = 2'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      slot0 <= 8'h00;
      slot1 <= 8'h00;
      slot_cnt <= 2'h0;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      slot_cnt <= next_slot_cnt;
    end
  end

  assign net_rx_valid = slot_cnt != 2'h0;
  assign net_rx_data = slot0;

  // FIFO trigger indication; without FIFO any byte triggers
  logic [12:0] trig_level;
  always_comb begin
    case (trig)
      2'h0: trig_level = RX_TRIG_0;
      2'h1: trig_level = RX_TRIG_1;
      2'h2: trig_level = RX_TRIG_2;
      default: trig_level = RX_TRIG_3;
    endcase
    rx_trigger_hit = fifo_en ? rx_level >= trig_level : rx_level != 13'h0000;
  end

  // Transmit gating and in-band XON/XOFF injection
  logic tx_go, slot_free, xoff_sent, next_xoff_sent, inj_xoff, inj_xon, tx_ctrl;
  logic tx_valid, next_tx_valid, tx_inj, next_tx_inj;
  logic [7:0] next_tx_data;

  // Ignored inputs and profiles without flow control leave tx_go high
  assign tx_go = !(cts_f == IN_FLOW && !cts_in) && !(dsr_f == IN_FLOW && !dsr_in)
    && !(xrx_en && xoff_held);
  assign slot_free = !tx_valid || ser_tx_ready;
  assign inj_xoff = xtx_en && rx_full && !xoff_sent;
  assign inj_xon = xtx_en && !rx_full && xoff_sent;
  assign tx_ctrl = net_tx_data == XON_CHAR || net_tx_data == XOFF_CHAR;
  assign net_tx_ready = slot_free && !inj_xoff && !inj_xon && (tx_go || (tflt && tx_ctrl));
  assign ser_tx_valid = tx_valid && (tx_go || tx_inj);

  always_comb begin
    next_tx_valid = tx_valid && !ser_tx_ready;
    next_tx_inj = tx_inj;
    next_tx_data = ser_tx_data;
    next_xoff_sent = xoff_sent;
    if (slot_free && inj_xoff) begin
      next_tx_valid = 1'b1;
      next_tx_inj = 1'b1;
      next_tx_data = XOFF_CHAR;
      next_xoff_sent = 1'b1;
    end else if (slot_free && inj_xon) begin
      next_tx_valid = 1'b1;
      next_tx_inj = 1'b1;
      next_tx_data = XON_CHAR;
      next_xoff_sent = 1'b0;
    end else if (net_tx_valid && net_tx_ready && !(tflt && tx_ctrl)) begin
      next_tx_valid = 1'b1;
      next_tx_inj = 1'b0;
      next_tx_data = net_tx_data;
    end
    if (!xtx_en || cfg_save) begin
      next_xoff_sent = 1'b0;
    end
    if (cfg_save) begin
      next_tx_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_valid <= 1'b0;
      tx_inj <= 1'b0;
      ser_tx_data <= 8'h00;
      xoff_sent <= 1'b0;
    end else begin
      tx_valid <= next_tx_valid;
      tx_inj <= next_tx_inj;
      ser_tx_data <= next_tx_data;
      xoff_sent <= next_xoff_sent;
    end
  end

  // Output line level for a given function
  function automatic logic line_level(input out_func_t f, input logic ovr_en,
                                      input logic ovr_lvl, input logic full,
                                      input logic conn);
    case (f)
      OUT_FLOW: line_level = !full;
      OUT_SHOW_CONN: line_level = conn;
      OUT_UNUSED_HIGH: line_level = ovr_en ? ovr_lvl : 1'b1;
      OUT_UNUSED_LOW: line_level = ovr_en ? ovr_lvl : 1'b0;
      default: line_level = 1'b1;
    endcase
  endfunction : line_level

  // Control lines and connection requests
  logic next_rts, next_dtr, next_open, next_close, next_accept, oc_used, oc_high;
  always_comb begin
    next_rts = line_level(rts_f, rts_ovr_en, rts_ovr_level, rx_full, tcp_connected);
    next_dtr = line_level(dtr_f, dtr_ovr_en, dtr_ovr_level, rx_full, tcp_connected);
    oc_used = cts_f == IN_OPEN_CLOSE || dsr_f == IN_OPEN_CLOSE;
    oc_high = (cts_f == IN_OPEN_CLOSE && cts_in) || (dsr_f == IN_OPEN_CLOSE && dsr_in);
    next_open = client_mode && dest_stored && oc_high;
    next_close = client_mode && dest_stored && oc_used && !oc_high;
    next_accept = !(cts_f == IN_ACCEPT_GATE && !cts_in)
      && !(dsr_f == IN_ACCEPT_GATE && !dsr_in);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rts_out <= 1'b1;
      dtr_out <= 1'b0;
      conn_open_req <= 1'b0;
      conn_close_req <= 1'b0;
      accept_allow <= 1'b1;
    end else begin
      rts_out <= next_rts;
      dtr_out <= next_dtr;
      conn_open_req <= next_open;
      conn_close_req <= next_close;
      accept_allow <= next_accept;
    end
  end

endmodule : serial_flow_control_line_config

// ==== dv/serial_flow_control_line_config_assertions.sv ====
`timescale 1ns/1ns
module serial_flow_checker
  import serial_flow_pkg::*;
#(
  parameter int RX_BUF_DEPTH = 4096
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cfg_save,
  input wire logic [1:0] cfg_profile,
  input wire logic tcp_connected,
  input wire logic cts_in,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_valid,
  input wire logic ser_tx_ready,
  input wire logic [7:0] ser_rx_data,
  input wire logic ser_rx_valid,
  input wire logic [7:0] net_rx_data,
  input wire logic net_rx_valid,
  input wire logic net_rx_ready,
  input wire logic [12:0] rx_level,
  input wire logic rts_out,
  input wire logic dtr_out,
  input wire logic accept_allow,
  input wire logic conn_open_req,
  input wire logic conn_close_req
);
  logic [1:0] prof, next_prof, age, next_age;
  logic st;
  // Active profile and edges since the last save
  always_comb begin
    next_prof = cfg_save ? cfg_profile : prof;
    next_age = cfg_save ? 2'h0 : age + {1'h0, age != 2'h3};
    if (!resetn) begin
      next_prof = 2'h1;
      next_age = 2'h0;
    end
  end
  always_ff @(posedge core_clk) begin
    prof <= next_prof;
    age <= next_age;
  end
  assign st = age == 2'h3;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_none_lines_high: assert property (st && prof == PROFILE_NONE |-> rts_out && dtr_out)
    else $error("lines not high without flow control");
  a_none_tx_holds: assert property (st && prof == PROFILE_NONE && ser_tx_valid && !ser_tx_ready
    && !cfg_save |=> ser_tx_valid)
    else $error("serial output withdrawn without flow control");
  a_hw_dtr_conn: assert property (st && prof == PROFILE_HARDWARE |-> dtr_out == $past(tcp_connected))
    else $error("connection line does not follow link state");
  a_hw_rts_empty: assert property (st && prof == PROFILE_HARDWARE && $past(rx_level) == 13'h0000
    |-> rts_out)
    else $error("flow line low with empty store");
  a_hw_cts_gate: assert property (st && prof == PROFILE_HARDWARE && !cts_in && !$past(cts_in)
    |-> !ser_tx_valid)
    else $error("serial output while clear line low");
  a_tx_data_held: assert property (ser_tx_valid && !ser_tx_ready && !cfg_save
    |=> $stable(ser_tx_data))
    else $error("serial byte changed before taken");
  a_rx_held: assert property (net_rx_valid && !net_rx_ready && !cfg_save
    |=> net_rx_valid && $stable(net_rx_data))
    else $error("network byte changed before taken");
  a_rx_latency: assert property (rx_level == 13'h0000 && !net_rx_valid && ser_rx_valid
    && ser_rx_data != XON_CHAR && ser_rx_data != XOFF_CHAR && !cfg_save ##1 !cfg_save
    |-> rx_level == 13'h0001 ##1 net_rx_valid && net_rx_data == $past(ser_rx_data, 2))
    else $error("received byte not forwarded in time");
  a_rx_level_cap: assert property (rx_level <= 13'h0FFE)
    else $error("store level above largest size");
  a_fixed_no_conn: assert property (st && prof != PROFILE_SPECIAL
    |-> accept_allow && !conn_open_req && !conn_close_req)
    else $error("connection control active in fixed profile");
  c_rts_drop: cover property (prof == PROFILE_SPECIAL && $fell(rts_out));
  c_tx_take: cover property (ser_tx_valid && ser_tx_ready);
  c_rx_take: cover property (net_rx_valid && net_rx_ready);
endmodule : serial_flow_checker

bind serial_flow_control_line_config serial_flow_checker #(.RX_BUF_DEPTH(RX_BUF_DEPTH))
  i_serial_flow_checker (.*);

// ==== dv/terminal_model.sv ====
`timescale 1ns/1ns
module terminal_model (
  input wire logic core_clk,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_valid,
  output logic ser_tx_ready,
  output logic [7:0] ser_rx_data,
  output logic ser_rx_valid,
  output logic cts_in,
  output logic dsr_in
);
  logic [7:0] got[$];
  // Idle levels; clear and open lines high
  initial begin
    ser_tx_ready = 1'h1;
    ser_rx_data = 8'h00;
    ser_rx_valid = 1'h0;
    cts_in = 1'h1;
    dsr_in = 1'h1;
  end
  // Take bytes at the ready edge, stalling every other cycle
  always @(posedge core_clk) begin
    if (ser_tx_valid && ser_tx_ready) got.push_back(ser_tx_data);
    ser_tx_ready <= !ser_tx_ready;
  end
  // Strobe n bytes from b upward, then scramble the idle data
  task automatic put(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      ser_rx_data <= b + 8'(i);
      ser_rx_valid <= 1'h1;
      @(posedge core_clk);
    end
    ser_rx_valid <= 1'h0;
    ser_rx_data <= ~b;
  endtask : put
endmodule : terminal_model

// ==== dv/serial_flow_control_line_config_tb.sv ====
`timescale 1ns/1ns
module serial_flow_control_line_config_tb;
  import serial_flow_pkg::*;
  logic core_clk = 1'h0, resetn = 1'h0, cfg_save = 1'h0;
  logic [1:0] cfg_profile = 2'h1, cfg_rts_func = 2'h0, cfg_dtr_func = 2'h0;
  logic [1:0] cfg_cts_func = 2'h0, cfg_dsr_func = 2'h0, cfg_fifo_trig = 2'h0;
  logic cfg_xon_rx_en = 1'h0, cfg_xon_tx_en = 1'h0, cfg_tx_filter = 1'h0;
  logic cfg_rx_filter = 1'h0, cfg_fifo_en = 1'h0, client_mode = 1'h0, dest_stored = 1'h0;
  logic [12:0] cfg_rx_buf_size = 13'h0FFE, rx_level;
  logic tcp_connected = 1'h0, rts_ovr_en = 1'h0, rts_ovr_level = 1'h0;
  logic dtr_ovr_en = 1'h0, dtr_ovr_level = 1'h0, net_tx_valid = 1'h0, net_rx_ready = 1'h1;
  logic [7:0] net_tx_data = 8'h00, ser_tx_data, ser_rx_data, net_rx_data;
  logic conn_open_req, conn_close_req, accept_allow, net_tx_ready, ser_tx_valid;
  logic ser_tx_ready, ser_rx_valid, net_rx_valid, rx_trigger_hit, rts_out, dtr_out;
  logic cts_in, dsr_in;
  logic [7:0] rx_got[$];
  int fail_count = 0, cmp_count = 0, cyc = 0;
  serial_flow_control_line_config i_serial_flow_control_line_config (.*);
  terminal_model i_terminal_model (.*);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Collect network bytes and cut a hang short
  always @(posedge core_clk) begin
    if (net_rx_valid && net_rx_ready) rx_got.push_back(net_rx_data);
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [12:0] seen, input logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic lines(input logic c, input logic d);
    i_terminal_model.cts_in <= c;
    i_terminal_model.dsr_in <= d;
  endtask : lines
  task automatic save(input logic [1:0] p, input logic [7:0] fn, input logic [3:0] x,
                      input logic [12:0] sz);
    cfg_profile <= p;
    {cfg_rts_func, cfg_dtr_func, cfg_cts_func, cfg_dsr_func} <= fn;
    {cfg_xon_rx_en, cfg_xon_tx_en, cfg_tx_filter, cfg_rx_filter} <= x;
    cfg_rx_buf_size <= sz;
    cfg_save <= 1'h1;
    tick(1);
    cfg_save <= 1'h0;
    tick(3);
  endtask : save
  // Hand n bytes from b upward to the block, each held until taken or for at most 60 cycles
  task automatic net_send(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      net_tx_data <= b + 8'(i);
      net_tx_valid <= 1'h1;
      // Ready is settled mid-cycle and holds until the taking edge
      for (int k = 0; k < 60; k++) begin
        @(negedge core_clk);
        if (net_tx_ready === 1'h1) break;
      end
      tick(1);
    end
    net_tx_valid <= 1'h0;
  endtask : net_send
  task automatic expect_ser(input logic [7:0] b);
    for (int k = 0; k < 60 && i_terminal_model.got.size() == 0; k++) tick(1);
    chk("serial count", 13'(i_terminal_model.got.size()), 13'h0001);
    if (i_terminal_model.got.size() != 0) chk("serial byte", i_terminal_model.got.pop_front(), b);
  endtask : expect_ser
  task automatic t_reset;
    @(negedge core_clk);
    chk("rts", rts_out, 1'h1);
    chk("dtr", dtr_out, 1'h0);
    tick(1);
    tcp_connected <= 1'h1;
    tick(3);
    chk("dtr", dtr_out, 1'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_hw_gate;
    lines(1'h0, 1'h0);
    fork net_send(8'h41, 1); join_none
    tick(10);
    chk("gated tx", 13'(i_terminal_model.got.size()), 13'h0000);
    lines(1'h1, 1'h0);
    expect_ser(8'h41);
    tick(2);
    $display("test hardware gate done");
  endtask : t_hw_gate
  task automatic t_none;
    tcp_connected <= 1'h0;
    lines(1'h0, 1'h0);
    save(PROFILE_NONE, 8'h00, 4'h0, 13'h0FFE);
    chk("rts", rts_out, 1'h1);
    chk("dtr", dtr_out, 1'h1);
    net_send(8'h50, 1);
    expect_ser(8'h50);
    tick(1);
    net_send(8'h51, 1);
    expect_ser(8'h51);
    $display("test no flow done");
  endtask : t_none
  task automatic t_full;
    save(PROFILE_SPECIAL, {OUT_FLOW, OUT_UNUSED_LOW, IN_IGNORED, IN_IGNORED}, 4'h4, 13'h0021);
    chk("dtr", dtr_out, 1'h0);
    dtr_ovr_en <= 1'h1;
    dtr_ovr_level <= 1'h1;
    net_rx_ready <= 1'h0;
    i_terminal_model.put(8'h20, 40);
    tick(3);
    chk("dtr override", dtr_out, 1'h1);
    chk("level", rx_level, 13'h0020);
    chk("trigger", rx_trigger_hit, 1'h1);
    chk("rts", rts_out, 1'h0);
    expect_ser(XOFF_CHAR);
    net_rx_ready <= 1'h1;
    dtr_ovr_en <= 1'h0;
    tick(60);
    chk("rts", rts_out, 1'h1);
    expect_ser(XON_CHAR);
    chk("kept", 13'(rx_got.size()), 13'h0022);
    chk("first", rx_got[0], 8'h20);
    chk("last", rx_got[33], 8'h41);
    rx_got.delete();
    $display("test full store done");
  endtask : t_full
  task automatic t_soft;
    save(PROFILE_SOFTWARE, 8'h00, 4'h0, 13'h0FFE);
    chk("dtr", dtr_out, 1'h1);
    net_send(XON_CHAR, 1);
    tick(1);
    net_send(8'h42, 1);
    expect_ser(8'h42);
    i_terminal_model.put(XOFF_CHAR, 1);
    tick(2);
    fork net_send(8'h43, 1); join_none
    tick(10);
    chk("halted", 13'(i_terminal_model.got.size()), 13'h0000);
    i_terminal_model.put(XON_CHAR, 1);
    expect_ser(8'h43);
    chk("swallowed", 13'(rx_got.size()), 13'h0000);
    $display("test software done");
  endtask : t_soft
  task automatic t_special;
    client_mode <= 1'h1;
    dest_stored <= 1'h1;
    cfg_fifo_en <= 1'h1;
    lines(1'h0, 1'h1);
    save(PROFILE_SPECIAL, {OUT_SHOW_CONN, OUT_UNUSED_HIGH, IN_ACCEPT_GATE, IN_OPEN_CLOSE},
         4'h1, 13'h0FFE);
    chk("accept", accept_allow, 1'h0);
    chk("open", conn_open_req, 1'h1);
    chk("rts", rts_out, 1'h0);
    lines(1'h1, 1'h0);
    tick(3);
    chk("accept", accept_allow, 1'h1);
    chk("close", conn_close_req, 1'h1);
    net_send(XOFF_CHAR, 1);
    expect_ser(XOFF_CHAR);
    i_terminal_model.put(XON_CHAR, 1);
    tick(6);
    chk("rx filtered", 13'(rx_got.size()), 13'h0000);
    chk("trigger", rx_trigger_hit, 1'h0);
    $display("test special done");
  endtask : t_special
  initial begin
    tick(5);
    resetn <= 1'h1;
    t_reset();
    t_hw_gate();
    t_none();
    t_full();
    t_soft();
    t_special();
    end_sim();
  end
endmodule : serial_flow_control_line_config_tb
